// File: common/odt_pkg.sv
// orientation debounce block: register map, field layout and angle tables
`default_nettype none
package odt_pkg;
  localparam int ORI_W = 4;
  localparam int ANG_W = 9;
  localparam int X10_W = 10;
  localparam int PL_W  = 11;
  localparam int NUM_EV = 2;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATE    = 8'h28;
  localparam logic [7:0] IDX_SETUP    = 8'h29;
  localparam logic [7:0] IDX_SETTLE   = 8'h2a;
  localparam logic [7:0] IDX_BFTILT   = 8'h2b;
  localparam logic [7:0] IDX_TRIP     = 8'h2c;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h30;
  localparam logic [7:0] IDX_IRQ_CLR  = 8'h31;
  localparam logic [7:0] IDX_IRQ_EN   = 8'h32;
  localparam logic [7:0] RST_SETUP    = 8'h80;
  localparam logic [7:0] RST_SETTLE   = 8'h00;
  localparam logic [7:0] RST_BFTILT   = 8'h44;
  localparam logic [7:0] RST_TRIP     = 8'h84;
  localparam logic [1:0] RST_IRQ_EN   = 2'h0;
  localparam int SETUP_MODE_BIT = 7;
  localparam int BF_LSB    = 6;
  localparam int ZLOCK_LSB = 0;
  localparam int THS_LSB   = 3;
  localparam int HYS_LSB   = 0;
  localparam int EV_CHANGE = 0;
  localparam int EV_FREEZE = 1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // back/front limits in degrees, shifted by one step per code
  localparam logic [ANG_W-1:0] BF_B2F_LO = 9'h050;
  localparam logic [ANG_W-1:0] BF_B2F_HI = 9'h118;
  localparam logic [ANG_W-1:0] BF_F2B_LO = 9'h064;
  localparam logic [ANG_W-1:0] BF_F2B_HI = 9'h104;
  localparam logic [ANG_W-1:0] BF_STEP   = 9'h005;
  // angles in tenths of a degree
  localparam logic [X10_W-1:0] ZMIN_X10 [8] = '{10'd136, 10'd171, 10'd207,
    10'd244, 10'd281, 10'd320, 10'd361, 10'd404};
  localparam logic [X10_W-1:0] ZMAX_X10 [8] = '{10'd145, 10'd182, 10'd220,
    10'd259, 10'd300, 10'd342, 10'd387, 10'd434};
  localparam logic [X10_W-1:0] THS_X10 [32] = '{10'd0, 10'd18, 10'd38,
    10'd59, 10'd81, 10'd105, 10'd130, 10'd156, 10'd184, 10'd214, 10'd244,
    10'd276, 10'd310, 10'd344, 10'd379, 10'd414, 10'd450, 10'd486, 10'd521,
    10'd556, 10'd590, 10'd624, 10'd656, 10'd686, 10'd716, 10'd744, 10'd770,
    10'd795, 10'd819, 10'd841, 10'd862, 10'd882};
  localparam logic [X10_W-1:0] HYS_X10 [8] = '{10'd0, 10'd40, 10'd70,
    10'd110, 10'd140, 10'd170, 10'd210, 10'd240};

  function automatic logic odt_reg_known(input logic [7:0] idx);
    return (idx >= IDX_STATE && idx <= IDX_TRIP) ||
           (idx >= IDX_IRQ_STAT && idx <= IDX_IRQ_EN);
  endfunction

  function automatic logic [ANG_W-1:0] odt_bf_shift(input logic [1:0] code);
    return ANG_W'(BF_STEP * code);
  endfunction
endpackage
`default_nettype wire

// File: core/odt_axil_slave.sv
// AXI4-Lite slave front end of the orientation register file
`timescale 1ns/1ps
`default_nettype none
module odt_axil_slave #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   wr_en,
  output logic [7:0]             wr_idx,
  output logic [7:0]             wr_data,
  output logic [7:0]             rd_idx,
  input  wire logic [31:0]       rd_word
);
  import odt_pkg::*;
  if (ADDR_W < 11) begin : g_bad_width
    $error("odt_axil_slave needs ADDR_W of at least 11");
  end
  logic              aw_have_r;
  logic              w_have_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0]        wdata_r;
  logic              wlane_r;
  logic              ar_known;
  logic              aw_known;
  assign rd_idx   = araddr[9:2];
  assign ar_known = odt_reg_known(araddr[9:2]) && araddr[ADDR_W-1:10] == '0;
  assign aw_known = odt_reg_known(awaddr_r[9:2]) &&
                    awaddr_r[ADDR_W-1:10] == '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wlane_r   <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      wr_en     <= 1'b0;
      wr_idx    <= '0;
      wr_data   <= '0;
    end else begin
      wr_en <= 1'b0;
      if (awvalid && awready) begin
        awaddr_r  <= awaddr;
        aw_have_r <= 1'b1;
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        wdata_r  <= wdata[7:0];
        wlane_r  <= wstrb[0];
        w_have_r <= 1'b1;
        wready   <= 1'b0;
      end
      if (aw_have_r && w_have_r && !bvalid) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= aw_known ? RESP_OKAY : RESP_SLVERR;
        wr_en     <= aw_known && wlane_r;
        wr_idx    <= awaddr_r[9:2];
        wr_data   <= wdata_r;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= ar_known ? rd_word : '0;
      rresp   <= ar_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule // odt_axil_slave
`default_nettype wire

// File: core/odt_settle_counter.sv
// per-sample debounce counter that validates a new orientation
`timescale 1ns/1ps
`default_nettype none
module odt_settle_counter #(
  parameter int CNT_W = 8
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      tick,
  input  wire logic                      freeze,
  input  wire logic                      restart,
  input  wire logic                      clear_mode,
  input  wire logic [CNT_W-1:0]          settle,
  input  wire logic [odt_pkg::ORI_W-1:0] orient_now,
  output logic [CNT_W-1:0]               count,
  output logic [odt_pkg::ORI_W-1:0]      candidate,
  output logic [odt_pkg::ORI_W-1:0]      reported,
  output logic                           changed
);
  import odt_pkg::*;
  if (CNT_W < 1) begin : g_bad_width
    $error("odt_settle_counter needs CNT_W of at least 1");
  end
  logic             seen_r;
  logic [CNT_W-1:0] count_nxt;
  assign count_nxt = (&count) ? count : count + 1'b1;

  always_ff @(posedge clk) begin
    if (rst || restart) begin
      count     <= '0;
      candidate <= '0;
      reported  <= '0;
      seen_r    <= 1'b0;
      changed   <= 1'b0;
    end else begin
      changed <= 1'b0;
      if (tick && !freeze) begin
        if (orient_now != candidate) begin
          candidate <= orient_now;
          if (clear_mode) count <= '0;
          else if (count != '0) count <= count - 1'b1;
        end else begin
          count <= count_nxt;
          if (count_nxt >= settle && (!seen_r || candidate != reported))
          begin
            reported <= candidate;
            seen_r   <= 1'b1;
            changed  <= 1'b1;
          end
        end
      end
    end
  end
endmodule // odt_settle_counter
`default_nettype wire

// File: core/odt_orient_core.sv
// orientation debounce and trip-angle configuration with register file
//
// Overview of operation
// - counter steps once per output sample period
// - flag only once the counter reaches the settle count
// - mode and wake/sleep changes clear counter
// - high acceleration freezes the counter
// - orientation change: decrement, or clear by mode
// - back/front field bits 7:6, reset 01
// - back/front Z transition angles per code
// - tilt lockout field bits 2:0, reset 28.1
// - lockout codes map to min/max angles
// - threshold bits 7:3, hysteresis 2:0, reset
// - trip angles are threshold plus/minus hysteresis
`timescale 1ns/1ps
`default_nettype none
module odt_orient_core #(
  parameter int ADDR_W = 12
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ADDR_W-1:0]         s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      sample_tick,
  input  wire logic                      device_active,
  input  wire logic                      wake_mode,
  input  wire logic                      high_accel,
  input  wire logic [odt_pkg::ORI_W-1:0] orient_now,
  output logic                           orientation_changed_flag,
  output logic                           irq,
  output logic [odt_pkg::ORI_W-1:0]      orient_state,
  output logic [odt_pkg::ANG_W-1:0]      b2f_low_deg,
  output logic [odt_pkg::ANG_W-1:0]      b2f_high_deg,
  output logic [odt_pkg::ANG_W-1:0]      f2b_low_deg,
  output logic [odt_pkg::ANG_W-1:0]      f2b_high_deg,
  output logic [odt_pkg::X10_W-1:0]      zlock_min_x10,
  output logic [odt_pkg::X10_W-1:0]      zlock_max_x10,
  output logic [odt_pkg::PL_W-1:0]       l2p_x10,
  output logic [odt_pkg::PL_W-1:0]       p2l_x10
);
  import odt_pkg::*;

  logic [7:0]        setup_r;
  logic [7:0]        settle_r;
  logic [7:0]        bftilt_r;
  logic [7:0]        trip_r;
  logic [NUM_EV-1:0] irq_stat_r;
  logic [NUM_EV-1:0] irq_stat_nxt;
  logic [NUM_EV-1:0] irq_en_r;
  logic [NUM_EV-1:0] irq_set;
  logic [NUM_EV-1:0] irq_clr;
  logic              active_q_r;
  logic              wake_q_r;
  logic              high_q_r;
  logic              restart_r;
  logic              wr_en;
  logic [7:0]        wr_idx;
  logic [7:0]        wr_data;
  logic [7:0]        rd_idx;
  logic [31:0]       rd_word;
  logic [7:0]        count_w;
  logic [ORI_W-1:0]  cand_w;
  logic [ORI_W-1:0]  reported_w;
  logic              changed_w;
  logic [1:0]        bf_code;
  logic [2:0]        zl_code;
  logic [4:0]        ths_code;
  logic [2:0]        hys_code;

  assign bf_code  = bftilt_r[BF_LSB +: 2];
  assign zl_code  = bftilt_r[ZLOCK_LSB +: 3];
  assign ths_code = trip_r[THS_LSB +: 5];
  assign hys_code = trip_r[HYS_LSB +: 3];

  odt_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .clk     (clk),
    .rst     (rst),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .rd_idx  (rd_idx),
    .rd_word (rd_word)
  );

  // configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      setup_r  <= RST_SETUP;
      settle_r <= RST_SETTLE;
      bftilt_r <= RST_BFTILT;
      trip_r   <= RST_TRIP;
      irq_en_r <= RST_IRQ_EN;
    end else if (wr_en) begin
      if (wr_idx == IDX_SETUP) setup_r <= wr_data;
      else if (wr_idx == IDX_SETTLE) settle_r <= wr_data;
      else if (wr_idx == IDX_BFTILT) bftilt_r <= wr_data;
      else if (wr_idx == IDX_TRIP) trip_r <= wr_data;
      else if (wr_idx == IDX_IRQ_EN) irq_en_r <= wr_data[NUM_EV-1:0];
    end
  end

  // the read-only state word comes straight from the debounce logic
  always_comb begin
    rd_word = '0;
    if (rd_idx == IDX_STATE) rd_word = 32'(reported_w);
    else if (rd_idx == IDX_SETUP) rd_word = 32'(setup_r);
    else if (rd_idx == IDX_SETTLE) rd_word = 32'(settle_r);
    else if (rd_idx == IDX_BFTILT) rd_word = 32'(bftilt_r);
    else if (rd_idx == IDX_TRIP) rd_word = 32'(trip_r);
    else if (rd_idx == IDX_IRQ_STAT) rd_word = 32'(irq_stat_r);
    else if (rd_idx == IDX_IRQ_EN) rd_word = 32'(irq_en_r);
  end

  // mode watch: any edge of active/standby or wake/sleep restarts
  always_ff @(posedge clk) begin
    if (rst) begin
      active_q_r <= 1'b0;
      wake_q_r   <= 1'b0;
      high_q_r   <= 1'b0;
      restart_r  <= 1'b0;
    end else begin
      active_q_r <= device_active;
      wake_q_r   <= wake_mode;
      high_q_r   <= high_accel;
      restart_r  <= (device_active ^ active_q_r) |
                    (wake_mode ^ wake_q_r);
    end
  end

  // restart beats freeze: a mode change always empties the counter
  odt_settle_counter #(
    .CNT_W (8)
  ) u_settle (
    .clk        (clk),
    .rst        (rst),
    .tick       (sample_tick),
    .freeze     (high_accel),
    .restart    (restart_r),
    .clear_mode (setup_r[SETUP_MODE_BIT]),
    .settle     (settle_r),
    .orient_now (orient_now),
    .count      (count_w),
    .candidate  (cand_w),
    .reported   (reported_w),
    .changed    (changed_w)
  );

  // sticky events; a set in the clear cycle wins
  always_comb begin
    irq_set = '0;
    irq_set[EV_CHANGE] = changed_w;
    irq_set[EV_FREEZE] = high_accel & ~high_q_r;
    irq_clr = (wr_en && wr_idx == IDX_IRQ_CLR) ? wr_data[NUM_EV-1:0] : '0;
    irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_r <= '0;
      irq <= 1'b0;
      orientation_changed_flag <= 1'b0;
      orient_state <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq <= |(irq_stat_r & irq_en_r);
      orientation_changed_flag <= irq_stat_nxt[EV_CHANGE];
      orient_state <= reported_w;
    end
  end

  // decoded trip angles, registered so the detector sees clean levels
  always_ff @(posedge clk) begin
    if (rst) begin
      b2f_low_deg   <= '0;
      b2f_high_deg  <= '0;
      f2b_low_deg   <= '0;
      f2b_high_deg  <= '0;
      zlock_min_x10 <= '0;
      zlock_max_x10 <= '0;
      l2p_x10       <= '0;
      p2l_x10       <= '0;
    end else begin
      b2f_low_deg   <= BF_B2F_LO - odt_bf_shift(bf_code);
      b2f_high_deg  <= BF_B2F_HI + odt_bf_shift(bf_code);
      f2b_low_deg   <= BF_F2B_LO + odt_bf_shift(bf_code);
      f2b_high_deg  <= BF_F2B_HI - odt_bf_shift(bf_code);
      zlock_min_x10 <= ZMIN_X10[zl_code];
      zlock_max_x10 <= ZMAX_X10[zl_code];
      l2p_x10 <= PL_W'(THS_X10[ths_code]) + PL_W'(HYS_X10[hys_code]);
      // low thresholds would go negative; clamp at zero degrees
      if (THS_X10[ths_code] > HYS_X10[hys_code])
        p2l_x10 <= PL_W'(THS_X10[ths_code] - HYS_X10[hys_code]);
      else
        p2l_x10 <= '0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence live_tick_s;
    sample_tick && !high_accel && !restart_r;
  endsequence

  sequence moved_s;
    live_tick_s and (orient_now != cand_w);
  endsequence

  // an accepted change shows on the flag one edge later and is still in the sticky bit on the edge after
  sequence flag_then_sticky_s;
    ##1 orientation_changed_flag ##1 irq_stat_r[EV_CHANGE];
  endsequence

  sequence mode_edge_s;
    $changed(device_active) || $changed(wake_mode);
  endsequence

  sequence restart_then_empty_s;
    restart_r ##1 count_w == 8'h00;
  endsequence

  tick_only_a:
    assert property (!sample_tick && !restart_r |=> $stable(count_w))
    else $error("settle counter moved without a sample tick");

  settle_gate_a:
    assert property (changed_w |-> count_w >= $past(settle_r))
    else $error("orientation accepted before settle count reached");

  flag_set_a:
    assert property (changed_w |-> flag_then_sticky_s)
    else $error("orientation change did not raise the flag");

  mode_restart_a:
    assert property (mode_edge_s |=> restart_then_empty_s)
    else $error("mode change did not clear the counter");

  freeze_hold_a:
    assert property (high_accel && !restart_r |=> $stable(count_w))
    else $error("counter moved under high acceleration");

  clear_mode_a:
    assert property (moved_s and setup_r[SETUP_MODE_BIT] |=> count_w == 8'h00)
    else $error("clear mode did not clear the counter");

  dec_mode_a:
    assert property (moved_s and !setup_r[SETUP_MODE_BIT] and count_w != 8'h00
                     |=> count_w == $past(count_w) - 8'h01)
    else $error("decrement mode did not step down");

  dec_floor_a:
    assert property (moved_s and !setup_r[SETUP_MODE_BIT] and count_w == 8'h00
                     |=> count_w == 8'h00)
    else $error("decrement mode stepped below zero");

  restart_empty_a:
    assert property (restart_r |=> count_w == 8'h00 && cand_w == '0 &&
                     reported_w == '0)
    else $error("restart left debounce state behind");

  freeze_event_a:
    assert property ($rose(high_accel) |=> irq_stat_r[EV_FREEZE])
    else $error("high acceleration did not set its event bit");

  reg_reset_a:
    assert property ($fell(rst) |-> bftilt_r == RST_BFTILT &&
                     trip_r == RST_TRIP && settle_r == RST_SETTLE)
    else $error("configuration not at reset values");

  bf_angle_a:
    assert property (!$past(rst) |-> b2f_low_deg + b2f_high_deg == 9'h168 &&
                     f2b_low_deg == BF_F2B_LO + odt_bf_shift($past(bf_code)))
    else $error("back/front angles do not follow the code");

  zlock_angle_a:
    assert property (!$past(rst) |-> zlock_min_x10 == ZMIN_X10[$past(zl_code)]
                     && zlock_max_x10 > zlock_min_x10)
    else $error("lockout angle does not follow the code");

  pl_trip_a:
    assert property (!$past(rst) |-> l2p_x10 ==
                     PL_W'(THS_X10[$past(ths_code)]) +
                     PL_W'(HYS_X10[$past(hys_code)]))
    else $error("trip angle is not threshold plus hysteresis");

  reg_write_a:
    assert property (wr_en && wr_idx == IDX_TRIP |=> trip_r == $past(wr_data))
    else $error("trip register did not take the write");

  irq_level_a:
    assert property (irq_stat_r[EV_CHANGE] && irq_en_r[EV_CHANGE]
                     && !rst |=> irq)
    else $error("enabled event did not raise the interrupt");

  sticky_clear_a:
    assert property (irq_clr[EV_CHANGE] && !changed_w
                     |=> !irq_stat_r[EV_CHANGE])
    else $error("clear write left the change bit set");

  irq_quiet_a:
    assert property (!(|(irq_stat_r & irq_en_r)) |=> !irq)
    else $error("interrupt raised with no enabled event");

  state_follow_a:
    assert property (orient_state == $past(reported_w))
    else $error("state output lost the accepted orientation");
endmodule // odt_orient_core
`default_nettype wire

// File: verif/odt_host_model.sv
// host-side AXI4-Lite master that reaches the register file
`timescale 1ns/1ps
`default_nettype none
module odt_host_model (
  input  wire logic        clk,
  output logic [11:0]      awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [11:0]      araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // each channel keeps valid and payload until its own ready edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h00_0000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule // odt_host_model
`default_nettype wire

// File: verif/orientation_debounce_and_trip_config_test.sv
// self-checking bench for orientation debounce and trip configuration
`timescale 1ns/1ps
`default_nettype none
module orientation_debounce_and_trip_config_test;
  import odt_pkg::*;
  logic             clk, rst, tick, act, wake, hacc, flag, irq, mode;
  logic [11:0]      awaddr, araddr;
  logic [31:0]      wdata, rdata;
  logic [3:0]       wstrb, ori, ost;
  logic [1:0]       bresp, rresp;
  logic             awvalid, awready, wvalid, wready, bvalid, bready;
  logic             arvalid, arready, rvalid, rready;
  logic [ANG_W-1:0] b2l, b2h, f2l, f2h;
  logic [X10_W-1:0] zmn, zmx;
  logic [PL_W-1:0]  l2p, p2l;
  int errors, checked, seed, cyc, cnt, cand, acc, anyacc, mflag, settle;
  int zmin[8] = '{136, 171, 207, 244, 281, 320, 361, 404};

  odt_orient_core u_dut (.clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sample_tick(tick), .device_active(act),
    .wake_mode(wake), .high_accel(hacc), .orient_now(ori),
    .orientation_changed_flag(flag), .irq(irq), .orient_state(ost),
    .b2f_low_deg(b2l), .b2f_high_deg(b2h), .f2b_low_deg(f2l),
    .f2b_high_deg(f2h), .zlock_min_x10(zmn), .zlock_max_x10(zmx),
    .l2p_x10(l2p), .p2l_x10(p2l));
  odt_host_model u_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // generous ceiling: the whole run needs well under ten thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      finish_test;
    end
  end
  task wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    u_host.wr(idx, d, r);
    check(32'(r), 32'(er));
  endtask
  task rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] r;
    u_host.rd(idx, v, r);
    check(v, {24'h00_0000, e});
    check(32'(r), 32'(er));
  endtask
  task restart(input logic w);
    @(posedge clk);
    if (w) wake <= ~wake;
    else act <= ~act;
    {cnt, cand, acc, anyacc} = '0;
    repeat (4) @(posedge clk);
    check(32'(ost), 32'h0);
  endtask
  task step(input logic [3:0] o, input logic h);
    @(posedge clk);
    ori <= o;
    hacc <= h;
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    if (!h) begin
      if (32'(o) != cand) begin
        cand = 32'(o);
        cnt = mode ? 0 : (cnt > 0 ? cnt - 1 : 0);
      end else begin
        if (cnt < 255) cnt++;
        if (cnt >= settle && (!anyacc || cand != acc)) begin
          acc = cand;
          anyacc = 1;
          mflag = 1;
        end
      end
    end
    repeat (4) @(posedge clk);
    check(32'(ost), 32'(acc));
    check(32'(flag), 32'(mflag));
    check(32'(irq), 32'(mflag));
  endtask

  initial begin
    int t;
    seed = 84;
    {rst, tick, act, wake, hacc, ori} = '1;
    {tick, act, wake, hacc, ori} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check(32'(b2l), 32'd75);
    check(32'(zmn), 32'd281);
    check(32'(l2p), 32'd590);
    check(32'(p2l), 32'd310);
    rd(IDX_SETUP, RST_SETUP, RESP_OKAY);
    rd(IDX_SETTLE, 8'h00, RESP_OKAY);
    rd(IDX_BFTILT, 8'h44, RESP_OKAY);
    rd(IDX_TRIP, 8'h84, RESP_OKAY);
    rd(8'h40, 8'h00, RESP_SLVERR);
    wr(8'h40, 8'h5a, RESP_SLVERR);
    wr(IDX_STATE, 8'h5a, RESP_OKAY);
    rd(IDX_STATE, 8'h00, RESP_OKAY);
    for (int c = 0; c < 8; c++) begin
      wr(IDX_BFTILT, {c[1:0], 3'b000, c[2:0]}, RESP_OKAY);
      repeat (3) @(posedge clk);
      check(32'(b2l), 32'(80 - 5 * (c & 3)));
      check(32'(b2h), 32'(280 + 5 * (c & 3)));
      check(32'(f2l), 32'(100 + 5 * (c & 3)));
      check(32'(f2h), 32'(260 - 5 * (c & 3)));
      check(32'(zmn), 32'(zmin[c]));
      check(32'(zmx), 32'(ZMAX_X10[c]));
      rd(IDX_BFTILT, {c[1:0], 3'b000, c[2:0]}, RESP_OKAY);
    end
    for (int h = 0; h < 8; h++) begin
      t = (h == 0) ? 16 : ($random(seed) & 31);
      wr(IDX_TRIP, {t[4:0], h[2:0]}, RESP_OKAY);
      repeat (3) @(posedge clk);
      check(32'(l2p), 32'(THS_X10[t]) + 32'(HYS_X10[h]));
      check(32'(p2l), THS_X10[t] > HYS_X10[h] ?
            32'(THS_X10[t] - HYS_X10[h]) : 32'h0);
      rd(IDX_TRIP, {t[4:0], h[2:0]}, RESP_OKAY);
    end
    wr(IDX_IRQ_EN, 8'h02, RESP_OKAY);
    hacc <= 1'b1;
    repeat (4) @(posedge clk);
    check(32'(irq), 32'h1);
    rd(IDX_IRQ_STAT, 8'h02, RESP_OKAY);
    wr(IDX_IRQ_EN, 8'h00, RESP_OKAY);
    repeat (3) @(posedge clk);
    check(32'(irq), 32'h0);
    wr(IDX_IRQ_CLR, 8'h03, RESP_OKAY);
    rd(IDX_IRQ_CLR, 8'h00, RESP_OKAY);
    rd(IDX_IRQ_STAT, 8'h00, RESP_OKAY);
    hacc <= 1'b0;
    wr(IDX_IRQ_EN, 8'h01, RESP_OKAY);
    mode = 1'b1;
    {settle, mflag, cnt, cand, acc, anyacc} = '0;
    for (int i = 0; i < 400; i++) begin
      case ($random(seed) & 15)
        0: restart(1'b0);
        1: restart(1'b1);
        2: begin
          mode = 1'($random(seed));
          wr(IDX_SETUP, {mode, 7'h00}, RESP_OKAY);
        end
        3: begin
          settle = $random(seed) & 3;
          wr(IDX_SETTLE, 8'(settle), RESP_OKAY);
        end
        4: begin
          wr(IDX_IRQ_CLR, 8'h01, RESP_OKAY);
          mflag = 0;
        end
        default: step(4'($random(seed)) & 4'h5, ($random(seed) & 7) == 0);
      endcase
    end
    finish_test;
  end
endmodule // orientation_debounce_and_trip_config_test
`default_nettype wire
